/* core/peripheral_clock_gate_ctrl.sv */
// peripheral clock gate register bank with wishbone access
// assumes one system clock, synchronous reset, 32-bit classic wishbone
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - ctrl1 bits 15..11 turn off timers five down to one when set
// - ctrl1 bit 8 turns off codec serial interface
// - ctrl1 bits 7,6,5 turn off i2c, uart b, uart a
// - ctrl1 bits 4,3 turn off spi b, spi a
// - ctrl1 bit 1 turns off can unit
// - ctrl1 bit 0 turns off adc
// - ctrl2 bits 15,14,9,8 turn off capture 8,7,2,1
// - ctrl2 bits 3..0 turn off compare 4..1
// - ctrl3 bit 10 turns off comparator
// - ctrl3 bits 9,8 turn off calendar clock and parallel port
// - ctrl3 bits 7,6 turn off crc unit and dac
// - unimplemented bits read zero and ignore writes
// - all disable bits clear at reset, present peripherals enabled two cycles after reset ends
// - disable bits read back last written value
// - disabled peripheral gets no clock and no register access
// - setting or clearing reaches the enables two cycles after the register is written
// - enabled only when bit clear and peripheral present
module peripheral_clock_gate_ctrl #(
  parameter logic [25:0] PRESENT = 26'h3FFFFFF,
  parameter int unsigned GATE_DELAY = clk_gate_pkg::GATE_DELAY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [25:0] clk_en_o,
  output logic [25:0] reg_en_o
);

  if (GATE_DELAY < 1) begin : g_bad_delay
    $error("peripheral_clock_gate_ctrl: gate delay must be at least one");
  end

  // ==========================================
  // helpers
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wdat,
                                        input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wdat[15:8];
    end
    merge = v & mask;
  endfunction

  // ==========================================
  // bus slave
  logic take;
  logic ack_w;

  wb_reg_slave u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_w),
    .take_o(take)
  );

  // ==========================================
  // registers
  logic [15:0] ctrl1_ff;
  logic [15:0] ctrl2_ff;
  logic [15:0] ctrl3_ff;
  logic [15:0] nxt_ctrl1;
  logic [15:0] nxt_ctrl2;
  logic [15:0] nxt_ctrl3;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [25:0] off_vec;
  logic [25:0] clk_en_w;
  logic [25:0] reg_en_w;

  always_comb begin
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_ctrl3 = ctrl3_ff;
    nxt_rdat = rdat_ff;
    if (take && we_i) begin
      case (adr_i)
        clk_gate_pkg::CTRL1_OFFSET: begin
          nxt_ctrl1 = merge(ctrl1_ff, dat_i, sel_i, clk_gate_pkg::CTRL1_MASK);
        end
        clk_gate_pkg::CTRL2_OFFSET: begin
          nxt_ctrl2 = merge(ctrl2_ff, dat_i, sel_i, clk_gate_pkg::CTRL2_MASK);
        end
        clk_gate_pkg::CTRL3_OFFSET: begin
          nxt_ctrl3 = merge(ctrl3_ff, dat_i, sel_i, clk_gate_pkg::CTRL3_MASK);
        end
        default: begin
        end
      endcase
    end
    if (take && !we_i) begin
      case (adr_i)
        clk_gate_pkg::CTRL1_OFFSET: begin
          nxt_rdat = {16'h0000, ctrl1_ff};
        end
        clk_gate_pkg::CTRL2_OFFSET: begin
          nxt_rdat = {16'h0000, ctrl2_ff};
        end
        clk_gate_pkg::CTRL3_OFFSET: begin
          nxt_rdat = {16'h0000, ctrl3_ff};
        end
        clk_gate_pkg::STATUS_OFFSET: begin
          nxt_rdat = {6'h00, clk_en_w};
        end
        default: begin
          nxt_rdat = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_ff <= clk_gate_pkg::CTRL1_RESET;
      ctrl2_ff <= clk_gate_pkg::CTRL2_RESET;
      ctrl3_ff <= clk_gate_pkg::CTRL3_RESET;
      rdat_ff <= 32'h00000000;
    end else begin
      ctrl1_ff <= nxt_ctrl1;
      ctrl2_ff <= nxt_ctrl2;
      ctrl3_ff <= nxt_ctrl3;
      rdat_ff <= nxt_rdat;
    end
  end

  // ==========================================
  // disable vector, one bit per peripheral
  always_comb begin
    off_vec[0] = ctrl1_ff[clk_gate_pkg::TIMER1_OFF_POS];
    off_vec[1] = ctrl1_ff[clk_gate_pkg::TIMER2_OFF_POS];
    off_vec[2] = ctrl1_ff[clk_gate_pkg::TIMER3_OFF_POS];
    off_vec[3] = ctrl1_ff[clk_gate_pkg::TIMER4_OFF_POS];
    off_vec[4] = ctrl1_ff[clk_gate_pkg::TIMER5_OFF_POS];
    off_vec[5] = ctrl1_ff[clk_gate_pkg::CODEC_IF_OFF_POS];
    off_vec[6] = ctrl1_ff[clk_gate_pkg::I2C_UNIT_OFF_POS];
    off_vec[7] = ctrl1_ff[clk_gate_pkg::UART_B_OFF_POS];
    off_vec[8] = ctrl1_ff[clk_gate_pkg::UART_A_OFF_POS];
    off_vec[9] = ctrl1_ff[clk_gate_pkg::SPI_B_OFF_POS];
    off_vec[10] = ctrl1_ff[clk_gate_pkg::SPI_A_OFF_POS];
    off_vec[11] = ctrl1_ff[clk_gate_pkg::CAN_UNIT_OFF_POS];
    off_vec[12] = ctrl1_ff[clk_gate_pkg::ADC_OFF_POS];
    off_vec[13] = ctrl2_ff[clk_gate_pkg::CAPTURE1_OFF_POS];
    off_vec[14] = ctrl2_ff[clk_gate_pkg::CAPTURE2_OFF_POS];
    off_vec[15] = ctrl2_ff[clk_gate_pkg::CAPTURE7_OFF_POS];
    off_vec[16] = ctrl2_ff[clk_gate_pkg::CAPTURE8_OFF_POS];
    off_vec[17] = ctrl2_ff[clk_gate_pkg::COMPARE1_OFF_POS];
    off_vec[18] = ctrl2_ff[clk_gate_pkg::COMPARE2_OFF_POS];
    off_vec[19] = ctrl2_ff[clk_gate_pkg::COMPARE3_OFF_POS];
    off_vec[20] = ctrl2_ff[clk_gate_pkg::COMPARE4_OFF_POS];
    off_vec[21] = ctrl3_ff[clk_gate_pkg::COMPARATOR_OFF_POS];
    off_vec[22] = ctrl3_ff[clk_gate_pkg::CALENDAR_CLOCK_OFF_POS];
    off_vec[23] = ctrl3_ff[clk_gate_pkg::PARALLEL_PORT_OFF_POS];
    off_vec[24] = ctrl3_ff[clk_gate_pkg::CRC_UNIT_OFF_POS];
    off_vec[25] = ctrl3_ff[clk_gate_pkg::DAC_OFF_POS];
  end

  // ==========================================
  // enable outputs
  gate_delay #(
    .WIDTH(clk_gate_pkg::PERIPH_COUNT),
    .DEPTH(GATE_DELAY)
  ) u_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .off_i(off_vec),
    .present_i(PRESENT),
    .clk_en_o(clk_en_w),
    .reg_en_o(reg_en_w)
  );

  assign clk_en_o = clk_en_w;
  assign reg_en_o = reg_en_w;
  assign dat_o = rdat_ff;
  assign ack_o = ack_w;

endmodule // peripheral_clock_gate_ctrl
`default_nettype wire

/* core/clk_gate_pkg.sv */
// constants for the peripheral clock gate register bank
// assumes a 32-bit classic wishbone slave and one system clock
package clk_gate_pkg;

  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned PERIPH_COUNT = 26;

  // ==========================================
  // register byte offsets
  localparam logic [3:0] CTRL1_OFFSET = 4'h0;
  localparam logic [3:0] CTRL2_OFFSET = 4'h4;
  localparam logic [3:0] CTRL3_OFFSET = 4'h8;
  localparam logic [3:0] STATUS_OFFSET = 4'hC;

  // ==========================================
  // implemented bit masks
  localparam logic [15:0] CTRL1_MASK = 16'hF9FB;
  localparam logic [15:0] CTRL2_MASK = 16'hC30F;
  localparam logic [15:0] CTRL3_MASK = 16'h07C0;
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  localparam logic [15:0] CTRL3_RESET = 16'h0000;

  // ==========================================
  // field positions, control register 1
  localparam int unsigned TIMER5_OFF_POS = 15;
  localparam int unsigned TIMER4_OFF_POS = 14;
  localparam int unsigned TIMER3_OFF_POS = 13;
  localparam int unsigned TIMER2_OFF_POS = 12;
  localparam int unsigned TIMER1_OFF_POS = 11;
  localparam int unsigned CODEC_IF_OFF_POS = 8;
  localparam int unsigned I2C_UNIT_OFF_POS = 7;
  localparam int unsigned UART_B_OFF_POS = 6;
  localparam int unsigned UART_A_OFF_POS = 5;
  localparam int unsigned SPI_B_OFF_POS = 4;
  localparam int unsigned SPI_A_OFF_POS = 3;
  localparam int unsigned CAN_UNIT_OFF_POS = 1;
  localparam int unsigned ADC_OFF_POS = 0;
  // control register 2
  localparam int unsigned CAPTURE8_OFF_POS = 15;
  localparam int unsigned CAPTURE7_OFF_POS = 14;
  localparam int unsigned CAPTURE2_OFF_POS = 9;
  localparam int unsigned CAPTURE1_OFF_POS = 8;
  localparam int unsigned COMPARE4_OFF_POS = 3;
  localparam int unsigned COMPARE3_OFF_POS = 2;
  localparam int unsigned COMPARE2_OFF_POS = 1;
  localparam int unsigned COMPARE1_OFF_POS = 0;
  // control register 3
  localparam int unsigned COMPARATOR_OFF_POS = 10;
  localparam int unsigned CALENDAR_CLOCK_OFF_POS = 9;
  localparam int unsigned PARALLEL_PORT_OFF_POS = 8;
  localparam int unsigned CRC_UNIT_OFF_POS = 7;
  localparam int unsigned DAC_OFF_POS = 6;

  // ==========================================
  // depth of the gate delay line; register to gate takes this plus one clock cycles
  localparam int unsigned GATE_DELAY_CYCLES = 1;

  // ==========================================
  // bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_type;

endpackage

/* core/wb_reg_slave.sv */
// classic wishbone slave decode and one-cycle ack
// assumes a master that holds the request until ack
`timescale 1ns/1ps
`default_nettype none
module wb_reg_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic take_o
);

  // ==========================================
  // ack state machine
  clk_gate_pkg::bus_state_type state_ff;
  clk_gate_pkg::bus_state_type nxt_state;

  always_comb begin
    case (state_ff)
      clk_gate_pkg::BUS_IDLE: begin
        nxt_state = (cyc_i && stb_i) ? clk_gate_pkg::BUS_ACK : clk_gate_pkg::BUS_IDLE;
      end
      clk_gate_pkg::BUS_ACK: begin
        nxt_state = clk_gate_pkg::BUS_IDLE;
      end
      default: begin
        nxt_state = clk_gate_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= clk_gate_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ack_o = (state_ff == clk_gate_pkg::BUS_ACK);
  assign take_o = (state_ff == clk_gate_pkg::BUS_IDLE) && cyc_i && stb_i;

endmodule // wb_reg_slave
`default_nettype wire

/* core/gate_delay.sv */
// delay line turning disable bits into gated enables
// assumes all inputs on clk_i
`timescale 1ns/1ps
`default_nettype none
module gate_delay #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] off_i,
  input wire logic [WIDTH-1:0] present_i,
  output logic [WIDTH-1:0] clk_en_o,
  output logic [WIDTH-1:0] reg_en_o
);

  if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("gate_delay: depth and width must be at least one");
  end

  // ==========================================
  // enable pipeline
  logic [WIDTH-1:0] stage_ff [DEPTH];
  logic [WIDTH-1:0] nxt_stage [DEPTH];
  logic [WIDTH-1:0] clk_en_ff;
  logic [WIDTH-1:0] reg_en_ff;
  logic [WIDTH-1:0] nxt_en;

  always_comb begin
    nxt_stage[0] = ~off_i & present_i;
    for (int i = 1; i < DEPTH; i++) begin
      nxt_stage[i] = stage_ff[i-1];
    end
    nxt_en = stage_ff[DEPTH-1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_ff[i] <= '0;
      end
      clk_en_ff <= '0;
      reg_en_ff <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_ff[i] <= nxt_stage[i];
      end
      clk_en_ff <= nxt_en;
      reg_en_ff <= nxt_en;
    end
  end

  assign clk_en_o = clk_en_ff;
  assign reg_en_o = reg_en_ff;

endmodule // gate_delay
`default_nettype wire

/* verif/clk_gate_sva.sv */
// checker for the clock gate register bank
// assumes a bind onto the top module ports
`timescale 1ns/1ps
`default_nettype none
module clk_gate_sva #(
  parameter logic [25:0] PRESENT = 26'h3FFFFFF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [25:0] clk_en_o,
  input wire logic [25:0] reg_en_o
);
  // ========
  // read mask of the addressed place
  logic [31:0] mask_ff;
  logic [31:0] nxt_mask;
  logic we_ff;
  always_comb begin
    case (adr_i)
      4'h0: nxt_mask = {16'h0000, clk_gate_pkg::CTRL1_MASK};
      4'h4: nxt_mask = {16'h0000, clk_gate_pkg::CTRL2_MASK};
      4'h8: nxt_mask = {16'h0000, clk_gate_pkg::CTRL3_MASK};
      4'hC: nxt_mask = 32'h03FFFFFF;
      default: nxt_mask = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    mask_ff <= nxt_mask;
    we_ff <= we_i;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ========
  // assertions
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  en_pair_a: assert property (clk_en_o == reg_en_o)
    else $error("clock and register enables differ");
  absent_off_a: assert property ((clk_en_o & ~PRESENT) == 26'h0000000)
    else $error("absent peripheral enabled");
  reset_on_a: assert property ($fell(rst_i) |-> ##[1:3] clk_en_o == PRESENT)
    else $error("enables not restored after reset");
  rd_mask_a: assert property (ack_o && !we_ff |-> (dat_o & ~mask_ff) == 32'h00000000)
    else $error("unimplemented bits read nonzero");
  gate_time_a: assert property (ack_o && we_ff && $past(adr_i) == 4'h0 && $past(sel_i[0])
    |-> ##2 clk_en_o[12] == (PRESENT[12] && !$past(dat_i[0], 3)))
    else $error("adc gate late or wrong");
  cover property (ack_o && we_ff);
  cover property (ack_o && !we_ff);
  cover property ($fell(clk_en_o[12]));
endmodule // clk_gate_sva
bind peripheral_clock_gate_ctrl clk_gate_sva #(.PRESENT(PRESENT)) clk_gate_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clk_en_o(clk_en_o), .reg_en_o(reg_en_o));
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the clock gate register bank
// assumes the package and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t got %h want %h", $time, (g), (e)); end end
module tb_top;
  logic clk_i;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic [25:0] clk_en_o;
  logic [25:0] reg_en_o;
  logic [15:0] shadow [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] mask [3] = '{clk_gate_pkg::CTRL1_MASK, clk_gate_pkg::CTRL2_MASK, clk_gate_pkg::CTRL3_MASK};
  int fails = 0;
  int samples_checked = 0;
  peripheral_clock_gate_ctrl peripheral_clock_gate_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clk_en_o(clk_en_o), .reg_en_o(reg_en_o));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ========
  // bus and model helpers
  function automatic logic [25:0] off_vec();
    logic [15:0] a, b, c;
    a = shadow[0];
    b = shadow[1];
    c = shadow[2];
    return {c[6], c[7], c[8], c[9], c[10], b[3:0], b[15], b[14], b[9], b[8], a[0], a[1],
      a[3], a[4], a[5], a[6], a[7], a[8], a[15:11]};
  endfunction
  task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input int r, input logic [3:0] s, input logic [15:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, 4'(4 * r), s, {16'hFFFF, d}, q);
    if (s[0]) shadow[r][7:0] = d[7:0];
    if (s[1]) shadow[r][15:8] = d[15:8];
  endtask
  task automatic check_all();
    logic [31:0] q;
    for (int r = 0; r < 3; r++) begin
      wb_cycle(1'b0, 4'(4 * r), 4'hF, 32'h00000000, q);
      `CHK(q, {16'h0000, shadow[r] & mask[r]})
    end
    wb_cycle(1'b0, 4'hC, 4'hF, 32'h00000000, q);
    `CHK(q, {6'h00, ~off_vec()})
    `CHK(clk_en_o, ~off_vec())
    `CHK(reg_en_o, ~off_vec())
  endtask
  // ========
  // scenarios
  task automatic t_walk();
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 16; b++) begin
        wr(r, 4'h3, 16'h0001 << b);
        check_all();
      end
      wr(r, 4'h3, 16'h0000);
    end
  endtask
  task automatic t_lanes();
    wr(0, 4'h1, 16'hFFFF);
    check_all();
    wr(0, 4'h2, 16'hFFFF);
    wr(1, 4'hC, 16'hFFFF);
    check_all();
    wr(0, 4'h3, 16'h0000);
  endtask
  task automatic t_timing();
    for (int v = 1; v >= 0; v--) begin
      wr(0, 4'h3, 16'(v));
      #1;
      `CHK(clk_en_o[12], 1'(v))
      @(posedge clk_i);
      #1;
      `CHK(clk_en_o[12], 1'(1 - v))
    end
  endtask
  task automatic t_unmapped();
    logic [31:0] q;
    wr(2, 4'h3, 16'hFFFF);
    wb_cycle(1'b1, 4'h5, 4'hF, 32'hFFFFFFFF, q);
    wb_cycle(1'b1, 4'hC, 4'hF, 32'h00000000, q);
    wb_cycle(1'b0, 4'h5, 4'hF, 32'h00000000, q);
    `CHK(q, 32'h00000000)
    check_all();
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    shadow = '{16'h0000, 16'h0000, 16'h0000};
    repeat (3) @(posedge clk_i);
    check_all();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check_all();
    t_walk();
    t_lanes();
    t_timing();
    t_unmapped();
    t_reset();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
